// [rtl/rpc_pkg.sv]
// package: register map, reset values and timing counts of the period/compare block
package rpc_pkg;

  // ==========================================================================
  // register indices as printed; byte address is four times the index
  localparam logic [5:0] RPC_IDX_STATUS       = 6'h01;
  localparam logic [5:0] RPC_IDX_COUNT_LOW    = 6'h08;
  localparam logic [5:0] RPC_IDX_COUNT_HIGH   = 6'h09;
  localparam logic [5:0] RPC_IDX_PERIOD_LOW   = 6'h0A;
  localparam logic [5:0] RPC_IDX_PERIOD_HIGH  = 6'h0B;
  localparam logic [5:0] RPC_IDX_COMPARE_LOW  = 6'h0C;
  localparam logic [5:0] RPC_IDX_COMPARE_HIGH = 6'h0D;

  // ==========================================================================
  // field layout and reset values
  localparam int          RPC_BYTE_W          = 8;
  localparam int          RPC_STATUS_PEND_BIT = 0;
  localparam logic [7:0]  RPC_PERIOD_BYTE_RST = 8'hFF;
  localparam logic [7:0]  RPC_COMPARE_BYTE_RST = 8'h00;
  localparam logic [15:0] RPC_PERIOD_RST      = {RPC_PERIOD_BYTE_RST, RPC_PERIOD_BYTE_RST};
  localparam logic [15:0] RPC_COMPARE_RST     = {RPC_COMPARE_BYTE_RST, RPC_COMPARE_BYTE_RST};

  // ==========================================================================
  // timing: counter-clock cycles a period write needs to reach the count
  localparam logic [1:0]  RPC_PERIOD_SYNC_TICKS = 2'd2;

endpackage : rpc_pkg

// [rtl/rpc_tick_sync.sv]
// module: two-flop synchroniser of the counter clock pin and rising-edge tick
`timescale 1ns/1ps
module rpc_tick_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic count_clk_pin,
  output logic      count_tick
);

  logic sync_first;
  logic sync_second;
  logic sync_prev;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      sync_prev   <= 1'b0;
      count_tick  <= 1'b0;
    end else begin
      sync_first  <= count_clk_pin;
      sync_second <= sync_first;
      sync_prev   <= sync_second;
      count_tick  <= sync_second & ~sync_prev;
    end
  end

endmodule // rpc_tick_sync

// [rtl/rpc_period_compare.sv]
// module: period and compare registers of a 16-bit real-time counter, APB slave
//
// What this block does
// - period is 16 bits at 0x0A, resets 0xFFFF
// - low byte bits 7:0 at base offset
// - high byte bits 15:8 at base plus one
// - period takes effect two counter-clock cycles later
// - every period bit is readable and writable
// - compare is 16 bits at 0x0C, resets 0x0000
// - counter is 16 bits, read as two bytes
//
// the counter clock arrives as a pin and is sampled on clk, so one counter
// cycle is a synchronised rising edge of that pin, three to four clk late
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module rpc_period_compare
  import rpc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              count_clk_pin,
  output logic                   period_sync_pending,
  output logic                   count_wrap,
  output logic                   compare_match
);

  // ==========================================================================
  // elaboration check
  generate
    if (ADDR_W < 8) begin : g_bad_addr
      $error("rpc_period_compare: ADDR_W must be at least 8");
    end
    if (RPC_PERIOD_SYNC_TICKS == 2'd0) begin : g_bad_sync
      $error("rpc_period_compare: period transfer needs at least one tick");
    end
  endgenerate

  // ==========================================================================
  // declarations
  logic [15:0] count_period;
  logic [15:0] count_compare;
  logic [15:0] period_active;
  logic [15:0] count_value;
  logic [1:0]  sync_ticks;
  logic        count_tick;
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;
  logic        sync_step;
  logic        sync_last;
  logic        load_active;
  logic        next_pending;
  logic [1:0]  next_sync_ticks;
  logic        at_period;
  logic        next_count_wrap;
  logic        next_compare_match;
  logic [15:0] next_count_value;

  // ==========================================================================
  // counter clock enters through a synchroniser
  rpc_tick_sync u_tick_sync (
    .clk           (clk),
    .rst_b         (rst_b),
    .count_clk_pin (count_clk_pin),
    .count_tick    (count_tick)
  );

  // ==========================================================================
  // APB decode
  function automatic logic idx_is(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
    idx_is = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == {{(ADDR_W-8){1'b0}}, idx});
  endfunction

  wire access_phase = psel & penable;
  wire bus_done     = access_phase & pready;
  wire hit_status   = idx_is(paddr, RPC_IDX_STATUS);
  wire hit_cnt_lo   = idx_is(paddr, RPC_IDX_COUNT_LOW);
  wire hit_cnt_hi   = idx_is(paddr, RPC_IDX_COUNT_HIGH);
  wire hit_per_lo   = idx_is(paddr, RPC_IDX_PERIOD_LOW);
  wire hit_per_hi   = idx_is(paddr, RPC_IDX_PERIOD_HIGH);
  wire hit_cmp_lo   = idx_is(paddr, RPC_IDX_COMPARE_LOW);
  wire hit_cmp_hi   = idx_is(paddr, RPC_IDX_COMPARE_HIGH);
  wire hit_any      = hit_status | hit_cnt_lo | hit_cnt_hi | hit_per_lo | hit_per_hi
                    | hit_cmp_lo | hit_cmp_hi;
  // read-only registers refuse writes with an error
  wire hit_ro       = hit_status | hit_cnt_lo | hit_cnt_hi;
  wire bad_access   = ~hit_any | (pwrite & hit_ro);
  wire wr_ok        = bus_done & pwrite & ~bad_access;
  wire wr_per_lo    = wr_ok & hit_per_lo;
  wire wr_per_hi    = wr_ok & hit_per_hi;
  wire wr_cmp_lo    = wr_ok & hit_cmp_lo;
  wire wr_cmp_hi    = wr_ok & hit_cmp_hi;
  wire wr_period    = wr_per_lo | wr_per_hi;
  wire [7:0] wbyte  = pwdata[7:0];

  wire [7:0] rd_byte =
      hit_status ? 8'({period_sync_pending} << RPC_STATUS_PEND_BIT) :
      hit_cnt_lo ? count_value[7:0] :
      hit_cnt_hi ? count_value[15:8] :
      hit_per_lo ? count_period[7:0] :
      hit_per_hi ? count_period[15:8] :
      hit_cmp_lo ? count_compare[7:0] :
      hit_cmp_hi ? count_compare[15:8] : 8'h00;

  // one wait state: answer is registered, so pready stays a flop output
  assign next_pready  = access_phase & ~pready;
  assign next_pslverr = next_pready & bad_access;
  assign next_prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= next_pready;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_pslverr;
    end
  end

  // read data is loaded only in the answering cycle and holds otherwise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (next_pready) begin
      prdata <= next_prdata;
    end
  end

  // ==========================================================================
  // period and compare registers
  // each byte is written on its own; no shadow latch pairs the two halves
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_period <= RPC_PERIOD_RST;
    end else begin
      if (wr_per_lo) count_period[7:0]  <= wbyte;
      if (wr_per_hi) count_period[15:8] <= wbyte;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_compare <= RPC_COMPARE_RST;
    end else begin
      if (wr_cmp_lo) count_compare[7:0]  <= wbyte;
      if (wr_cmp_hi) count_compare[15:8] <= wbyte;
    end
  end

  // ==========================================================================
  // period transfer into the counter side
  // a rewrite while pending restarts the wait: the write wins over the clear
  assign sync_step       = period_sync_pending & count_tick;
  assign sync_last       = sync_step & (sync_ticks == RPC_PERIOD_SYNC_TICKS - 2'd1);
  assign load_active     = sync_last & ~wr_period;
  assign next_pending    = wr_period | (period_sync_pending & ~sync_last);
  assign next_sync_ticks = wr_period ? 2'd0 : (sync_step ? sync_ticks + 2'd1 : sync_ticks);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      period_sync_pending <= 1'b0;
    end else begin
      period_sync_pending <= next_pending;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_ticks <= 2'd0;
    end else begin
      sync_ticks <= next_sync_ticks;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      period_active <= RPC_PERIOD_RST;
    end else if (load_active) begin
      period_active <= count_period;
    end
  end

  // ==========================================================================
  // 16-bit count, wrap and compare match
  // the count meets the transferred period, never the live register
  assign at_period          = (count_value == period_active);
  assign next_count_wrap    = count_tick & at_period;
  assign next_compare_match = count_tick & (count_value == count_compare);
  assign next_count_value   = at_period ? 16'h0000 : count_value + 16'h0001;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_value <= 16'h0000;
    end else if (count_tick) begin
      count_value <= next_count_value;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_wrap    <= 1'b0;
      compare_match <= 1'b0;
    end else begin
      count_wrap    <= next_count_wrap;
      compare_match <= next_compare_match;
    end
  end

endmodule // rpc_period_compare

// [verification/rpc_period_compare_sva.sv]
// checker: concurrent assertions on the ports of the period/compare block
`timescale 1ns/1ps
module rpc_period_compare_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              count_clk_pin,
  input wire logic              period_sync_pending,
  input wire logic              count_wrap,
  input wire logic              compare_match
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // named steps
  sequence s_taken; psel && penable && pready; endsequence
  sequence s_per_wr; s_taken ##0 (pwrite && (paddr == 8'h28 || paddr == 8'h2C)); endsequence
  // a rise of the pin six or more cycles back has already produced its tick
  sequence s_pin_quiet; (!count_clk_pin)[*6]; endsequence
  // ==========================================================================
  // assertions
  a_ready_access: assert property ($rose(penable) && psel |=> pready)
    else $error("no answer in access phase");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_pend_set: assert property (s_per_wr |=> period_sync_pending)
    else $error("pending not set by period write");
  a_pend_min: assert property ($rose(period_sync_pending) |-> period_sync_pending[*3])
    else $error("pending cleared too early");
  a_pend_quiet: assert property (s_pin_quiet ##0 period_sync_pending |=> period_sync_pending)
    else $error("pending cleared without a tick");
  a_map_ok: assert property (s_taken ##0 (paddr inside {8'h28, 8'h2C, 8'h30, 8'h34}) |-> !pslverr)
    else $error("mapped byte refused");
  a_unmapped: assert property (s_taken ##0 (paddr == 8'h3C) |-> pslverr)
    else $error("unmapped address accepted");
  a_rdata_byte: assert property (s_taken ##0 !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  a_wrap_pulse: assert property (count_wrap |=> !count_wrap)
    else $error("wrap pulse too long");
endmodule // rpc_period_compare_sva

// [verification/rpc_period_compare_tb_top.sv]
// testbench: APB register and period-transfer tests of the period/compare block
`timescale 1ns/1ps
module rpc_period_compare_tb_top;
  import rpc_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, count_clk_pin, pready, pslverr, err;
  logic        period_sync_pending, count_wrap, compare_match, wrap_seen, match_seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          failures, tests_run;
  rpc_period_compare dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .count_clk_pin(count_clk_pin), .period_sync_pending(period_sync_pending),
    .count_wrap(count_wrap), .compare_match(compare_match));
  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  // one counter-clock cycle; the tail lets the synchronised tick land
  task automatic tick;
    repeat (3) @(posedge clk);
    count_clk_pin <= 1'b1;
    repeat (3) @(posedge clk);
    count_clk_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic pwr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    tick();
    tick();
  endtask
  // ==========================================================================
  // clock, monitors and test sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrap_seen <= 1'b0;
      match_seen <= 1'b0;
    end else begin
      if (count_wrap === 1'b1) wrap_seen <= 1'b1;
      if (compare_match === 1'b1) match_seen <= 1'b1;
    end
  end
  initial begin
    {rst_b, psel, penable, pwrite, count_clk_pin} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rchk(RPC_IDX_PERIOD_LOW, 8'hFF);
    rchk(RPC_IDX_PERIOD_HIGH, 8'hFF);
    rchk(RPC_IDX_COMPARE_LOW, 8'h00);
    rchk(RPC_IDX_COMPARE_HIGH, 8'h00);
    rchk(RPC_IDX_COUNT_LOW, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 2; i++) begin
      pwr(RPC_IDX_PERIOD_LOW, i ? 8'hAA : 8'h55);
      pwr(RPC_IDX_PERIOD_HIGH, i ? 8'h55 : 8'hAA);
      rchk(RPC_IDX_PERIOD_LOW, i ? 8'hAA : 8'h55);
      rchk(RPC_IDX_PERIOD_HIGH, i ? 8'h55 : 8'hAA);
    end
    $display("period byte map done");
    apb(1'b1, RPC_IDX_PERIOD_LOW, 8'h40);
    @(negedge clk) chk(period_sync_pending, 1'b1);
    rchk(RPC_IDX_STATUS, 8'(1 << RPC_STATUS_PEND_BIT));
    tick();
    @(negedge clk) chk(period_sync_pending, 1'b1);
    tick();
    @(negedge clk) chk(period_sync_pending, 1'b0);
    rchk(RPC_IDX_STATUS, 8'h00);
    pwr(RPC_IDX_PERIOD_HIGH, 8'h00);
    $display("period transfer done");
    apb(1'b1, RPC_IDX_COMPARE_LOW, 8'h30);
    apb(1'b1, RPC_IDX_COMPARE_HIGH, 8'h00);
    rchk(RPC_IDX_COMPARE_LOW, 8'h30);
    repeat (60) tick();
    chk(wrap_seen, 1'b1);
    chk(match_seen, 1'b1);
    rchk(RPC_IDX_COUNT_LOW, 8'h07);
    rchk(RPC_IDX_COUNT_HIGH, 8'h00);
    apb(1'b1, RPC_IDX_COUNT_LOW, 8'h12);
    chk(err, 1'b1);
    rchk(RPC_IDX_COUNT_LOW, 8'h07);
    apb(1'b0, 6'h0F, 8'h00);
    chk(err, 1'b1);
    $display("count and refusal done");
    stop_test();
  end
endmodule // rpc_period_compare_tb_top
bind rpc_period_compare rpc_period_compare_sva #(.ADDR_W(ADDR_W)) u_sva (.clk(clk),
  .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .count_clk_pin(count_clk_pin), .period_sync_pending(period_sync_pending),
  .count_wrap(count_wrap), .compare_match(compare_match));
